// file: verilog/dsx_exec.sv
// Behaviour
// RULE1 - Immediate left shift, zero fill low
// RULE2 - Variable left shift, count from operand A
// RULE3 - Left shift by 32 plus count
// RULE4 - Immediate arithmetic right, sign fill
// RULE5 - Variable arithmetic right, sign fill
// RULE6 - Arithmetic right by 32 plus count
// RULE7 - Immediate logical right, zero fill high
// RULE8 - Variable logical right, zero fill high
// RULE9 - Logical right by 32 plus count
// RULE10 - Trapping subtract flags signed overflow
// RULE11 - Overflowing subtract writes no register
// RULE12 - Wrapping subtract always writes, never traps
// RULE13 - Return from trap has no slot
// RULE14 - Software never puts return in slot
// RULE15 - Error level: use error pc, clear
// RULE16 - Otherwise: use exception pc, clear
// RULE17 - Return clears the link valid flag
// RULE18 - Region jump target, after one slot
// RULE19 - Region jump with link writes r31
// RULE20 - Wrapping subtract is modulo two^64
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.svh"

module dsx_exec #(
   parameter int W = 64
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_b_in,
   // Issued instruction and status
   input  wire dsx_pkg::dsx_issue_t  issue_in,
   input  wire dsx_pkg::dsx_status_t status_in,
   // Register file write
   output dsx_pkg::dsx_wb_t          wb_out,
   // Program counter redirect
   output dsx_pkg::dsx_redirect_t    redirect_out,
   // Event pulses
   output logic                      trap_ovf_out,
   output logic                      clear_error_level_out,
   output logic                      clear_exception_level_out,
   output logic                      link_clear_out
);

   // Instruction fields
   logic [5:0]  opc;                 // Major opcode
   logic [5:0]  fn;                  // Function code
   logic [4:0]  dst_index;           // Destination index
   logic [4:0]  shift_count_field;   // Immediate count
   logic [25:0] tgt;                 // Region jump target
   logic        special;             // All-zero major opcode

   // Decoded operation flags
   logic        dword_shl_imm;
   logic        dword_shl_var;
   logic        dword_shl_imm_hi;
   logic        dword_sar_imm;
   logic        dword_sar_var;
   logic        dword_sar_imm_hi;
   logic        dword_shr_imm;
   logic        dword_shr_var;
   logic        dword_shr_imm_hi;
   logic        dword_minus_trap;
   logic        dword_minus_wrap;
   logic        return_from_trap;
   logic        region_branch;
   logic        region_branch_with_link;
   logic        any_shift;           // Any shift form

   // Datapath
   dsx_pkg::dsx_shift_kind_t sh_kind;  // Shift kind
   logic [5:0]  sh_amt;              // Final shift amount
   logic [W-1:0] sh_res;             // Shifter output
   logic [W-1:0] diff;               // Difference mod 2^64
   logic        ovf;                 // Signed overflow of difference

   // Registered outputs
   dsx_pkg::dsx_wb_t       wb_q;
   dsx_pkg::dsx_redirect_t redir_q;
   logic                   trap_q;
   logic                   clr_erl_q;
   logic                   clr_exl_q;
   logic                   link_clr_q;

   // Count field plus optional bias of 32
   function automatic logic [5:0] imm_amount(input logic [4:0] cnt, input logic hi);
      imm_amount = hi ? (`DSX_HI_BIAS | {1'b0, cnt}) : {1'b0, cnt};
   endfunction

   // Region target from delay-slot address and 26-bit field
   function automatic logic [63:0] region_target(input logic [63:0] pc, input logic [25:0] t);
      logic [63:0] slot;
      slot = pc + `DSX_INSTR_STEP;
      region_target = {slot[63:`DSX_REGION_LO], t, 2'b00};
   endfunction

   // Field extraction
   always_comb begin
      opc               = issue_in.instr[`DSX_OPC_HI:`DSX_OPC_LO];
      fn                = issue_in.instr[`DSX_FN_HI:`DSX_FN_LO];
      dst_index         = issue_in.instr[`DSX_D_HI:`DSX_D_LO];
      shift_count_field = issue_in.instr[`DSX_SC_HI:`DSX_SC_LO];
      tgt               = issue_in.instr[`DSX_TGT_HI:0];
      special           = (opc == `DSX_OP_SPECIAL);
   end

   // Operation decode
   always_comb begin
      dword_shl_imm           = special && (fn == `DSX_FN_SHL_IMM);
      dword_shl_var           = special && (fn == `DSX_FN_SHL_VAR);
      dword_shl_imm_hi        = special && (fn == `DSX_FN_SHL_IMM_HI);
      dword_sar_imm           = special && (fn == `DSX_FN_SAR_IMM);
      dword_sar_var           = special && (fn == `DSX_FN_SAR_VAR);
      dword_sar_imm_hi        = special && (fn == `DSX_FN_SAR_IMM_HI);
      dword_shr_imm           = special && (fn == `DSX_FN_SHR_IMM);
      dword_shr_var           = special && (fn == `DSX_FN_SHR_VAR);
      dword_shr_imm_hi        = special && (fn == `DSX_FN_SHR_IMM_HI);
      dword_minus_trap        = special && (fn == `DSX_FN_MINUS_TRAP);
      dword_minus_wrap        = special && (fn == `DSX_FN_MINUS_WRAP);
      return_from_trap        = (issue_in.instr == `DSX_RETURN_WORD);
      region_branch           = (opc == `DSX_OP_JUMP);
      region_branch_with_link = (opc == `DSX_OP_JUMP_LINK);
      any_shift = dword_shl_imm | dword_shl_var | dword_shl_imm_hi |
                  dword_sar_imm | dword_sar_var | dword_sar_imm_hi |
                  dword_shr_imm | dword_shr_var | dword_shr_imm_hi;
   end

   // Shift kind and amount selection
   always_comb begin
      if (dword_shl_imm | dword_shl_var | dword_shl_imm_hi) begin
         sh_kind = dsx_pkg::DSX_SHL;                          // [RULE1] [RULE2] [RULE3]
      end else if (dword_sar_imm | dword_sar_var | dword_sar_imm_hi) begin
         sh_kind = dsx_pkg::DSX_SAR;                          // [RULE4] [RULE5] [RULE6]
      end else begin
         sh_kind = dsx_pkg::DSX_SHR;                          // [RULE7] [RULE8] [RULE9]
      end
      if (dword_shl_var | dword_sar_var | dword_shr_var) begin
         sh_amt = issue_in.opa[5:0];                          // [RULE2] [RULE5] [RULE8]
      end else begin
         sh_amt = imm_amount(shift_count_field,
                             dword_shl_imm_hi | dword_sar_imm_hi | dword_shr_imm_hi);  // [RULE3] [RULE6] [RULE9]
      end
   end

   // Shared barrel shifter
   dsx_shifter #(
      .W  (W),
      .AW (6)
   ) u_shifter (
      .data_in    (issue_in.opb),
      .amount_in  (sh_amt),
      .kind_in    (sh_kind),
      .result_out (sh_res)
   );

   // Subtract with overflow detection
   always_comb begin
      diff = issue_in.opa - issue_in.opb;                     // [RULE20]
      // Carries out of bits 62 and 63 disagree
      ovf  = (issue_in.opa[63] != issue_in.opb[63]) && (diff[63] != issue_in.opa[63]);  // [RULE10]
   end

   // Register file write
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wb_q <= '0;
      end else begin
         wb_q.valid <= 1'b0;
         if (issue_in.valid) begin
            if (any_shift) begin
               wb_q.valid <= 1'b1;
               wb_q.index <= dst_index;
               wb_q.data  <= sh_res;
            end else if (dword_minus_wrap) begin
               wb_q.valid <= 1'b1;                            // [RULE12]
               wb_q.index <= dst_index;
               wb_q.data  <= diff;
            end else if (dword_minus_trap) begin
               wb_q.valid <= !ovf;                            // [RULE11]
               wb_q.index <= dst_index;
               wb_q.data  <= diff;
            end else if (region_branch_with_link) begin
               wb_q.valid <= 1'b1;                            // [RULE19]
               wb_q.index <= `DSX_LINK_REG;
               wb_q.data  <= issue_in.pc + `DSX_LINK_STEP;
            end
         end
      end
   end

   // Overflow trap pulse
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trap_q <= 1'b0;
      end else begin
         trap_q <= issue_in.valid && dword_minus_trap && ovf;  // [RULE10] [RULE12]
      end
   end

   // Program counter redirect
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         redir_q <= '0;
      end else begin
         redir_q.valid       <= 1'b0;
         redir_q.after_slot  <= 1'b0;
         redir_q.squash_next <= 1'b0;
         if (issue_in.valid && return_from_trap) begin
            // Return is never in a slot, so it redirects at once
            redir_q.valid       <= 1'b1;                      // [RULE14]
            redir_q.squash_next <= 1'b1;                      // [RULE13]
            if (status_in.error_level_flag) begin
               redir_q.target <= status_in.error_return_pc;   // [RULE15]
            end else begin
               redir_q.target <= status_in.exception_return_pc;  // [RULE16]
            end
         end else if (issue_in.valid && (region_branch || region_branch_with_link)) begin
            redir_q.valid      <= 1'b1;
            redir_q.after_slot <= 1'b1;                       // [RULE18]
            redir_q.target     <= region_target(issue_in.pc, tgt);  // [RULE18] [RULE19]
         end
      end
   end

   // Status clear pulses on return
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         clr_erl_q  <= 1'b0;
         clr_exl_q  <= 1'b0;
         link_clr_q <= 1'b0;
      end else begin
         clr_erl_q  <= issue_in.valid && return_from_trap && status_in.error_level_flag;   // [RULE15]
         clr_exl_q  <= issue_in.valid && return_from_trap && !status_in.error_level_flag;  // [RULE16]
         link_clr_q <= issue_in.valid && return_from_trap;                                // [RULE17]
      end
   end

   // Outputs straight from flops
   assign wb_out                    = wb_q;
   assign redirect_out              = redir_q;
   assign trap_ovf_out              = trap_q;
   assign clear_error_level_out     = clr_erl_q;
   assign clear_exception_level_out = clr_exl_q;
   assign link_clear_out            = link_clr_q;

   // Checks
   sequence s_issue_ret;
      issue_in.valid && return_from_trap;
   endsequence

   sequence s_trap_ovf;
      issue_in.valid && dword_minus_trap && ovf;
   endsequence

   a_shl_imm_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE1]
      issue_in.valid && dword_shl_imm |=> wb_q.valid &&
      wb_q.data == ($past(issue_in.opb) << $past(shift_count_field)))
      else $error("immediate left shift wrong");

   a_shl_hi_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE3]
      issue_in.valid && dword_shl_imm_hi |=>
      wb_q.data == ($past(issue_in.opb) << (32 + $past(shift_count_field))))
      else $error("left shift plus 32 wrong");

   a_sar_var_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE5]
      issue_in.valid && dword_sar_var |=>
      wb_q.data == 64'($signed($past(issue_in.opb)) >>> $past(issue_in.opa[5:0])))
      else $error("variable arithmetic shift wrong");

   a_shr_hi_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE9]
      issue_in.valid && dword_shr_imm_hi |=>
      wb_q.data == ($past(issue_in.opb) >> (32 + $past(shift_count_field))))
      else $error("logical shift plus 32 wrong");

   a_trap_no_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE11]
      s_trap_ovf |=> trap_q && !wb_q.valid)
      else $error("overflow trap wrote register");

   a_wrap_no_trap: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE12]
      issue_in.valid && dword_minus_wrap |=> !trap_q && wb_q.valid &&
      wb_q.data == $past(issue_in.opa) - $past(issue_in.opb))
      else $error("wrapping subtract wrong");

   a_ret_erl_path: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE15]
      s_issue_ret ##0 status_in.error_level_flag |=> redir_q.valid && clr_erl_q && !clr_exl_q &&
      redir_q.target == $past(status_in.error_return_pc))
      else $error("error level return wrong");

   a_ret_exl_path: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE16]
      s_issue_ret ##0 !status_in.error_level_flag |=> clr_exl_q && !clr_erl_q &&
      redir_q.target == $past(status_in.exception_return_pc))
      else $error("exception level return wrong");

   a_ret_link_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE17]
      s_issue_ret |=> link_clr_q && redir_q.squash_next && !redir_q.after_slot
      ##1 (link_clr_q == $past(issue_in.valid && return_from_trap)))
      else $error("return did not clear link flag");

   a_jal_link_addr: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [RULE19]
      issue_in.valid && region_branch_with_link |=> wb_q.valid && wb_q.index == 5'h1F &&
      wb_q.data == $past(issue_in.pc) + 64'h8 && redir_q.after_slot)
      else $error("jump with link wrong");

endmodule

`default_nettype wire

// file: verilog/dsx_defines.svh
`ifndef DSX_DEFINES_SVH
`define DSX_DEFINES_SVH

// Major opcodes
`define DSX_OP_SPECIAL      6'h00
`define DSX_OP_JUMP         6'h02
`define DSX_OP_JUMP_LINK    6'h03

// Function codes under the all-zero major opcode
`define DSX_FN_SHL_IMM      6'h38
`define DSX_FN_SHL_VAR      6'h14
`define DSX_FN_SHL_IMM_HI   6'h3C
`define DSX_FN_SAR_IMM      6'h3B
`define DSX_FN_SAR_VAR      6'h17
`define DSX_FN_SAR_IMM_HI   6'h3F
`define DSX_FN_SHR_IMM      6'h3A
`define DSX_FN_SHR_VAR      6'h16
`define DSX_FN_SHR_IMM_HI   6'h3E
`define DSX_FN_MINUS_TRAP   6'h2E
`define DSX_FN_MINUS_WRAP   6'h2F

// Whole instruction word of the return from trap
`define DSX_RETURN_WORD     32'h42000018

// Instruction field positions
`define DSX_OPC_HI          31
`define DSX_OPC_LO          26
`define DSX_A_HI            25
`define DSX_A_LO            21
`define DSX_B_HI            20
`define DSX_B_LO            16
`define DSX_D_HI            15
`define DSX_D_LO            11
`define DSX_SC_HI           10
`define DSX_SC_LO           6
`define DSX_FN_HI           5
`define DSX_FN_LO           0
`define DSX_TGT_HI          25

// Constants of the datapath
`define DSX_LINK_REG        5'h1F
`define DSX_HI_BIAS         6'h20
`define DSX_INSTR_STEP      64'h0000000000000004
`define DSX_LINK_STEP       64'h0000000000000008
`define DSX_REGION_LO       28

`endif

// file: verilog/dsx_pkg.sv
package dsx_pkg;

   // Shift direction and fill
   typedef enum logic [1:0] {
      DSX_SHL = 2'b00,
      DSX_SHR = 2'b01,
      DSX_SAR = 2'b10
   } dsx_shift_kind_t;

   // One issued instruction with its operands
   typedef struct packed {
      logic        valid;
      logic [31:0] instr;
      logic [63:0] opa;
      logic [63:0] opb;
      logic [63:0] pc;
   } dsx_issue_t;

   // Exception status seen by the return from trap
   typedef struct packed {
      logic        error_level_flag;
      logic        exception_level_flag;
      logic [63:0] exception_return_pc;
      logic [63:0] error_return_pc;
   } dsx_status_t;

   // Register file write
   typedef struct packed {
      logic        valid;
      logic [4:0]  index;
      logic [63:0] data;
   } dsx_wb_t;

   // Program counter redirect
   typedef struct packed {
      logic        valid;
      logic        after_slot;
      logic        squash_next;
      logic [63:0] target;
   } dsx_redirect_t;

endpackage

// file: verilog/dsx_shifter.sv
`timescale 1ns/1ps
`default_nettype none

// Barrel shifter for one doubleword
module dsx_shifter #(
   parameter int W  = 64,
   parameter int AW = 6
) (
   // Operand and amount
   input  wire logic [W-1:0]           data_in,
   input  wire logic [AW-1:0]          amount_in,
   input  wire dsx_pkg::dsx_shift_kind_t kind_in,
   // Shifted value
   output logic [W-1:0]                result_out
);

   // Shift by kind
   always_comb begin
      unique case (kind_in)
         dsx_pkg::DSX_SHL: begin
            result_out = data_in << amount_in;                  // Zero fill low
         end
         dsx_pkg::DSX_SHR: begin
            result_out = data_in >> amount_in;                  // Zero fill high
         end
         dsx_pkg::DSX_SAR: begin
            result_out = W'($signed(data_in) >>> amount_in);    // Sign fill high
         end
         default: begin
            result_out = '0;                                     // Unused code
         end
      endcase
   end

endmodule

`default_nettype wire

// file: verification/dsx_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.svh"

module testbench;

   // Clock and reset
   logic                    clk_in;
   logic                    rst_b_in;
   // Stimulus structs
   dsx_pkg::dsx_issue_t     issue_in;
   dsx_pkg::dsx_status_t    status_in;
   // Observed outputs
   dsx_pkg::dsx_wb_t        wb_out;
   dsx_pkg::dsx_redirect_t  redirect_out;
   logic                    trap_ovf_out;
   logic                    clear_error_level_out;
   logic                    clear_exception_level_out;
   logic                    link_clear_out;
   // Tallies
   int                      err_count = 0;
   int                      n_compared = 0;

   // Block under test
   dsx_exec DUT (
      .clk_in                    (clk_in),
      .rst_b_in                  (rst_b_in),
      .issue_in                  (issue_in),
      .status_in                 (status_in),
      .wb_out                    (wb_out),
      .redirect_out              (redirect_out),
      .trap_ovf_out              (trap_ovf_out),
      .clear_error_level_out     (clear_error_level_out),
      .clear_exception_level_out (clear_exception_level_out),
      .link_clear_out            (link_clear_out)
   );

   // Free running 250 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // Counts and verdict, single exit point
   task automatic tally_and_finish();
      $display("Compared %0d values, %0d mismatches", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Compare one value, four-state exact
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One issue slot; on return the outputs of the previous slot are settled
   task automatic drive(input logic v, input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                        input logic [63:0] p);
      @(posedge clk_in);
      issue_in <= '{valid: v, instr: ins, opa: a, opb: b, pc: p};
      @(negedge clk_in);
   endtask

   // Empty slot
   task automatic idle();
      drive(1'b0, 32'h0000_0000, 64'h0, 64'h0, 64'h0);
   endtask

   // Register write seen, no trap
   task automatic chk_wb(input logic [4:0] idx, input logic [63:0] d);
      chk(wb_out.valid, 64'h1);
      chk(wb_out.index, idx);
      chk(wb_out.data, d);
      chk(trap_ovf_out, 64'h0);
   endtask

   // Register-form instruction word, operand B index fixed at 2
   function automatic logic [31:0] mk_r(input logic [4:0] a, input logic [4:0] d, input logic [4:0] sa,
                                        input logic [5:0] fn);
      return {`DSX_OP_SPECIAL, a, 5'h02, d, sa, fn};
   endfunction

   // Reference shift: bit5 immediate, bit2 adds 32, low bits pick direction
   function automatic logic [63:0] shift_model(input logic [5:0] fn, input logic [63:0] src,
                                               input logic [4:0] sa, input logic [5:0] va);
      logic [6:0] s;
      s = fn[5] ? ({2'b00, sa} + (fn[2] ? 7'h20 : 7'h00)) : {1'b0, va};
      case (fn[1:0])
         2'b00:   return src << s;
         2'b11:   return 64'($signed(src) >>> s);
         default: return src >> s;
      endcase
   endfunction

   // All nine shifts back to back, extreme immediate counts, both source signs
   task automatic test_shifts();
      logic [5:0]  fns [9];
      logic [63:0] src;
      logic [63:0] a_val;
      logic [63:0] exp_prev;
      logic [4:0]  sa;
      logic        imm;
      fns = '{`DSX_FN_SHL_IMM, `DSX_FN_SHL_VAR, `DSX_FN_SHL_IMM_HI, `DSX_FN_SAR_IMM, `DSX_FN_SAR_VAR,
              `DSX_FN_SAR_IMM_HI, `DSX_FN_SHR_IMM, `DSX_FN_SHR_VAR, `DSX_FN_SHR_IMM_HI};
      exp_prev = 64'h0;
      for (int pass = 0; pass < 2; pass++) begin
         // Upper bits of operand A are junk the count must ignore
         src   = (pass == 0) ? 64'h8123_4567_89AB_CDEF : 64'h7EDC_BA98_7654_3210;
         sa    = (pass == 0) ? 5'h1F : 5'h00;
         a_val = (pass == 0) ? 64'hABCD_EF00_0000_0045 : 64'h0000_0000_0000_00FF;
         for (int i = 0; i < 9; i++) begin
            imm = fns[i][5];
            drive(1'b1, mk_r(imm ? 5'h00 : 5'h03, 5'(i + 1), imm ? sa : 5'h00, fns[i]), a_val, src, 64'h0);
            if (i > 0) begin
               chk_wb(5'(i), exp_prev);
            end
            exp_prev = shift_model(fns[i], src, sa, a_val[5:0]);
         end
         idle();
         chk_wb(5'h09, exp_prev);
      end
   endtask

   // Subtracts around the signed limits, trap and wrap interleaved
   task automatic test_subtract();
      drive(1'b1, mk_r(5'h03, 5'h0A, 5'h00, `DSX_FN_MINUS_TRAP), 64'h5, 64'h7, 64'h0);
      drive(1'b1, mk_r(5'h03, 5'h0B, 5'h00, `DSX_FN_MINUS_TRAP), 64'h8000_0000_0000_0000, 64'h1, 64'h0);
      chk_wb(5'h0A, 64'hFFFF_FFFF_FFFF_FFFE);
      drive(1'b1, mk_r(5'h03, 5'h0C, 5'h00, `DSX_FN_MINUS_WRAP), 64'h8000_0000_0000_0000, 64'h1, 64'h0);
      chk(trap_ovf_out, 64'h1);
      chk(wb_out.valid, 64'h0);
      drive(1'b1, mk_r(5'h03, 5'h0D, 5'h00, `DSX_FN_MINUS_TRAP), 64'h7FFF_FFFF_FFFF_FFFF,
            64'hFFFF_FFFF_FFFF_FFFF, 64'h0);
      chk_wb(5'h0C, 64'h7FFF_FFFF_FFFF_FFFF);
      drive(1'b1, mk_r(5'h03, 5'h0E, 5'h00, `DSX_FN_MINUS_WRAP), 64'h0, 64'h1, 64'h0);
      chk(trap_ovf_out, 64'h1);
      chk(wb_out.valid, 64'h0);
      idle();
      chk_wb(5'h0E, 64'hFFFF_FFFF_FFFF_FFFF);
   endtask

   // Return from trap at error level, then at exception level
   task automatic test_return();
      logic el;
      for (int k = 0; k < 2; k++) begin
         el = (k == 0);
         @(posedge clk_in);
         status_in <= '{error_level_flag: el, exception_level_flag: 1'b1,
                        exception_return_pc: 64'h0000_0000_8000_0180, error_return_pc: 64'hFFFF_FFFF_BFC0_0000};
         // Issued on its own, never behind a jump
         drive(1'b1, `DSX_RETURN_WORD, 64'h0, 64'h0, 64'h0000_0000_0040_0000);
         idle();
         chk(redirect_out.valid, 64'h1);
         chk(redirect_out.squash_next, 64'h1);
         chk(redirect_out.target, el ? 64'hFFFF_FFFF_BFC0_0000 : 64'h0000_0000_8000_0180);
         chk(clear_error_level_out, {63'h0, el});
         chk(clear_exception_level_out, {63'h0, !el});
         chk(link_clear_out, 64'h1);
         chk(wb_out.valid, 64'h0);
      end
   endtask

   // Region jumps where the slot address crosses a region boundary
   task automatic test_jump();
      logic [63:0] pc;
      logic [63:0] slot;
      logic [25:0] tgt;
      pc   = 64'h1234_5678_FFFF_FFFC;
      slot = pc + 64'h4;
      tgt  = 26'h2AB_CDEF;
      for (int lk = 0; lk < 2; lk++) begin
         drive(1'b1, {(lk == 1) ? `DSX_OP_JUMP_LINK : `DSX_OP_JUMP, tgt}, 64'h0, 64'h0, pc);
         idle();
         chk(redirect_out.valid, 64'h1);
         chk(redirect_out.after_slot, 64'h1);
         chk(redirect_out.squash_next, 64'h0);
         chk(redirect_out.target, {slot[63:28], tgt, 2'b00});
         chk(wb_out.valid, 64'(lk));
         if (lk == 1) begin
            chk(wb_out.index, 64'h1F);
            chk(wb_out.data, pc + 64'h8);
         end
      end
   endtask

   // Decodable words in empty slots and an unlisted function must all stay quiet
   task automatic test_quiet();
      drive(1'b0, `DSX_RETURN_WORD, 64'h0, 64'h0, 64'h0);
      drive(1'b0, {`DSX_OP_JUMP_LINK, 26'h000_0010}, 64'h0, 64'h0, 64'h0);
      chk(link_clear_out, 64'h0);
      chk(redirect_out.valid, 64'h0);
      drive(1'b0, mk_r(5'h03, 5'h0F, 5'h00, `DSX_FN_MINUS_TRAP), 64'h8000_0000_0000_0000, 64'h1, 64'h0);
      chk(wb_out.valid, 64'h0);
      chk(redirect_out.valid, 64'h0);
      drive(1'b1, mk_r(5'h03, 5'h10, 5'h00, 6'h20), 64'h8000_0000_0000_0000, 64'h1, 64'h0);
      chk(trap_ovf_out, 64'h0);
      idle();
      chk(wb_out.valid, 64'h0);
      chk(trap_ovf_out, 64'h0);
   endtask

   // Main sequence
   initial begin
      rst_b_in  = 1'b0;
      issue_in  = '0;
      status_in = '0;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      test_shifts();
      test_subtract();
      test_return();
      test_jump();
      test_quiet();
      idle();
      tally_and_finish();
   end

   // Hang guard, well beyond the fewer than fifty cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_in);
      err_count++;
      tally_and_finish();
   end

endmodule

`default_nettype wire
